// ===== hdl/interrupt_priority_select.sv
// Contract
// - a set priority bit means high level, a clear bit means low level
// - running handler is pre-empted only by a strictly higher level request
// - basic priority register at B8, individually bit addressable
// - extended priority register at F8, all eight bits read/write
// - basic bit 5 sets external interrupt 5 level
// - basic bit 2 sets external interrupt 1 level
// - basic bit 0 sets external interrupt 0 level
// - basic bit 4 sets serial port level
// - basic bit 3 sets timer 1 overflow level
// - basic bit 1 sets timer 0 overflow level
// - global gate must be set for any interrupt to be taken
// - external 6..13 each gated by own enable bit
`default_nettype none
module interrupt_priority_select #(
   parameter int NUM_SRC = irq_priority_pkg::NUM_SRC
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // special-function register port
   input wire irq_priority_pkg::sfr_req_t sfrReq,
   output logic [7:0] sfrRdata,
   output logic sfrRvalid,
   // request sources: 0 ext0,1 timer0,2 ext1,3 timer1,4 serial,5 ext5,6..13 ext6..13
   input wire logic [NUM_SRC-1:0] irqPending,
   // core handshake
   input wire logic irqAck,
   input wire logic handlerReturn,
   output irq_priority_pkg::irq_grant_t grant,
   // current levels seen by the controller
   output logic [NUM_SRC-1:0] srcLevel
);
   logic [7:0] basicVal;
   logic [7:0] extVal;
   logic [7:0] gateVal;
   logic [7:0] extGateVal;

   sfr_byte #(.ADDR(irq_priority_pkg::PRIO_BASIC_ADDR),
      .WMASK(irq_priority_pkg::PRIO_BASIC_WMASK)) u_basic (
      .clock(clock), .nrst(nrst), .req(sfrReq), .value(basicVal));
   sfr_byte #(.ADDR(irq_priority_pkg::PRIO_EXT_ADDR),
      .WMASK(8'hFF)) u_ext (
      .clock(clock), .nrst(nrst), .req(sfrReq), .value(extVal));
   sfr_byte #(.ADDR(irq_priority_pkg::IRQ_GATE_ADDR),
      .WMASK(irq_priority_pkg::IRQ_GATE_WMASK)) u_gate (
      .clock(clock), .nrst(nrst), .req(sfrReq), .value(gateVal));
   sfr_byte #(.ADDR(irq_priority_pkg::EXT_GATE_ADDR),
      .WMASK(8'hFF)) u_extgate (
      .clock(clock), .nrst(nrst), .req(sfrReq), .value(extGateVal));

   // register read mux
   logic [7:0] rdMux;
   assign rdMux =
      (sfrReq.addr == irq_priority_pkg::PRIO_BASIC_ADDR) ? basicVal :
      (sfrReq.addr == irq_priority_pkg::PRIO_EXT_ADDR) ? extVal :
      (sfrReq.addr == irq_priority_pkg::IRQ_GATE_ADDR) ? gateVal :
      (sfrReq.addr == irq_priority_pkg::EXT_GATE_ADDR) ? extGateVal :
      irq_priority_pkg::SFR_RESET;

   // per-source level and enable
   logic [NUM_SRC-1:0] levelVec;
   logic [NUM_SRC-1:0] enableVec;
   assign levelVec[irq_priority_pkg::EXT0_BIT] = basicVal[irq_priority_pkg::EXT0_BIT];
   assign levelVec[irq_priority_pkg::TIMER0_BIT] =
      basicVal[irq_priority_pkg::TIMER0_BIT];
   assign levelVec[irq_priority_pkg::EXT1_BIT] = basicVal[irq_priority_pkg::EXT1_BIT];
   assign levelVec[irq_priority_pkg::TIMER1_BIT] =
      basicVal[irq_priority_pkg::TIMER1_BIT];
   assign levelVec[irq_priority_pkg::SERIAL_BIT] =
      basicVal[irq_priority_pkg::SERIAL_BIT];
   assign levelVec[irq_priority_pkg::EXT5_BIT] = basicVal[irq_priority_pkg::EXT5_BIT];
   assign enableVec[irq_priority_pkg::BASIC_SRC-1:0] =
      gateVal[irq_priority_pkg::BASIC_SRC-1:0];
   genvar g;
   generate
      for (g = irq_priority_pkg::BASIC_SRC; g < NUM_SRC; g++) begin : gExt
         assign levelVec[g] = extVal[g-irq_priority_pkg::BASIC_SRC];
         assign enableVec[g] = extGateVal[g-irq_priority_pkg::BASIC_SRC];
      end
   endgenerate

   logic globalOn;
   assign globalOn = gateVal[irq_priority_pkg::GLOBAL_GATE_BIT];
   logic [NUM_SRC-1:0] liveVec;
   assign liveVec = irqPending & enableVec & {NUM_SRC{globalOn}};
   logic [NUM_SRC-1:0] liveHigh;
   logic [NUM_SRC-1:0] liveLow;
   assign liveHigh = liveVec & levelVec;
   assign liveLow = liveVec & ~levelVec;

   // fixed order: lowest index wins within a level
   function automatic logic [3:0] firstSet(input logic [NUM_SRC-1:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) idx = i[3:0];
      end
      return idx;
   endfunction

   logic [3:0] highIdx;
   logic [3:0] lowIdx;
   assign highIdx = firstSet(liveHigh);
   assign lowIdx = firstSet(liveLow);

   // nesting state: which levels are in service
   irq_priority_pkg::service_state_t state_reg;
   irq_priority_pkg::service_state_t state_next;
   logic highBusy;
   logic lowBusy;
   assign highBusy = state_reg[1];
   assign lowBusy = state_reg[0];
   // high may pre-empt low, nothing pre-empts high
   logic takeHigh;
   logic takeLow;
   assign takeHigh = (|liveHigh) && !highBusy;
   assign takeLow = (|liveLow) && !highBusy && !lowBusy && !takeHigh;

   irq_priority_pkg::irq_grant_t grant_reg;
   irq_priority_pkg::irq_grant_t grant_next;
   always_comb begin
      grant_next.valid = takeHigh || takeLow;
      grant_next.source = takeHigh ? highIdx : lowIdx;
      grant_next.level = takeHigh ? irq_priority_pkg::LEVEL_HIGH : irq_priority_pkg::LEVEL_LOW;
   end

   // ack commits the grant offered in the same cycle; return pops the top level
   always_comb begin
      state_next = state_reg;
      if (handlerReturn) begin
         case (state_reg)
            irq_priority_pkg::ST_BOTH: state_next = irq_priority_pkg::ST_LOW;
            irq_priority_pkg::ST_HIGH: state_next = irq_priority_pkg::ST_IDLE;
            irq_priority_pkg::ST_LOW: state_next = irq_priority_pkg::ST_IDLE;
            default: state_next = irq_priority_pkg::ST_IDLE;
         endcase
      end else if (irqAck && grant_reg.valid) begin
         case (state_reg)
            irq_priority_pkg::ST_IDLE: state_next = grant_reg.level ?
               irq_priority_pkg::ST_HIGH : irq_priority_pkg::ST_LOW;
            irq_priority_pkg::ST_LOW: state_next = grant_reg.level ?
               irq_priority_pkg::ST_BOTH : irq_priority_pkg::ST_LOW;
            default: state_next = state_reg;
         endcase
      end
   end

   logic [7:0] rdata_reg;
   logic rvalid_reg;
   logic [NUM_SRC-1:0] level_reg;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= irq_priority_pkg::ST_IDLE;
         grant_reg <= '0;
         rdata_reg <= irq_priority_pkg::SFR_RESET;
         rvalid_reg <= 1'b0;
         level_reg <= '0;
      end else begin
         state_reg <= state_next;
         // a grant acknowledged this cycle is withdrawn to avoid double take
         grant_reg <= (irqAck || handlerReturn) ? '0 : grant_next;
         rdata_reg <= sfrReq.rd ? rdMux : rdata_reg;
         rvalid_reg <= sfrReq.rd;
         level_reg <= levelVec;
      end
   end

   assign sfrRdata = rdata_reg;
   assign sfrRvalid = rvalid_reg;
   assign grant = grant_reg;
   assign srcLevel = level_reg;
endmodule
`default_nettype wire

// ===== hdl/sfr_byte.sv
`default_nettype none
module sfr_byte #(
   parameter logic [7:0] ADDR = 8'h00,
   parameter logic [7:0] WMASK = 8'hFF
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // access
   input wire irq_priority_pkg::sfr_req_t req,
   // contents
   output logic [7:0] value
);
   logic [7:0] value_reg;
   logic [7:0] value_next;
   logic hit;
   logic [7:0] bitMask;
   logic [7:0] merged;
   assign hit = req.wr && (req.addr == ADDR);
   assign bitMask = 8'h01 << req.bitSel;
   // bit op: wdata bit 0 is the new bit value
   assign merged = req.bitOp ?
      ((value_reg & ~bitMask) | ({8{req.wdata[0]}} & bitMask)) : req.wdata;
   assign value_next = hit ? (merged & WMASK) : value_reg;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) value_reg <= irq_priority_pkg::SFR_RESET;
      else value_reg <= value_next;
   end
   assign value = value_reg;
endmodule
`default_nettype wire

// ===== pkg/irq_priority_pkg.sv
`default_nettype none
package irq_priority_pkg;
   localparam int SFR_ADDR_W = 8;
   localparam int SFR_DATA_W = 8;
   localparam int NUM_SRC = 14;
   localparam int SRC_IDX_W = 4;
   localparam logic [7:0] PRIO_BASIC_ADDR = 8'hB8;
   localparam logic [7:0] PRIO_EXT_ADDR = 8'hF8;
   localparam logic [7:0] IRQ_GATE_ADDR = 8'hA8;
   localparam logic [7:0] EXT_GATE_ADDR = 8'hE8;
   localparam logic [7:0] SFR_RESET = 8'h00;
   localparam logic [7:0] PRIO_BASIC_WMASK = 8'h3F;
   localparam logic [7:0] IRQ_GATE_WMASK = 8'hBF;
   localparam int EXT0_BIT = 0;
   localparam int TIMER0_BIT = 1;
   localparam int EXT1_BIT = 2;
   localparam int TIMER1_BIT = 3;
   localparam int SERIAL_BIT = 4;
   localparam int EXT5_BIT = 5;
   localparam int GLOBAL_GATE_BIT = 7;
   localparam int BASIC_SRC = 6;
   localparam logic [0:0] LEVEL_LOW = 1'h0;
   localparam logic [0:0] LEVEL_HIGH = 1'h1;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic bitOp;
      logic [2:0] bitSel;
   } sfr_req_t;

   typedef struct packed {
      logic valid;
      logic [3:0] source;
      logic level;
   } irq_grant_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW = 2'b01,
      ST_HIGH = 2'b10,
      ST_BOTH = 2'b11
   } service_state_t;
endpackage
`default_nettype wire

// ===== verif/interrupt_priority_select_properties.sv
`default_nettype none
module interrupt_priority_select_properties #(parameter int NUM_SRC = 14) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // register port
   input wire irq_priority_pkg::sfr_req_t sfrReq,
   input wire logic [7:0] sfrRdata,
   input wire logic sfrRvalid,
   // interrupt side
   input wire logic [NUM_SRC-1:0] irqPending,
   input wire logic irqAck,
   input wire logic handlerReturn,
   input wire irq_priority_pkg::irq_grant_t grant,
   input wire logic [NUM_SRC-1:0] srcLevel
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   wire logic fullWr = sfrReq.wr && !sfrReq.bitOp;
   wire logic mapped = sfrReq.addr inside {8'hB8, 8'hF8, 8'hA8, 8'hE8};
   read_valid_a: assert property (sfrReq.rd |=> sfrRvalid) else $error("no read valid");
   top_zero_a: assert property (sfrReq.rd && sfrReq.addr == 8'hB8 |=> sfrRdata[7:6] == 2'h0)
      else $error("reserved bits set");
   unmapped_zero_a: assert property (sfrReq.rd && !mapped |=> sfrRdata == 8'h00)
      else $error("unmapped read not zero");
   ext_level_a: assert property (fullWr && sfrReq.addr == 8'hF8
      |-> ##2 srcLevel[13:6] == $past(sfrReq.wdata, 2)) else $error("ext levels wrong");
   basic_level_a: assert property (fullWr && sfrReq.addr == 8'hB8
      |-> ##2 srcLevel[5:0] == $past(sfrReq.wdata[5:0], 2)) else $error("basic levels wrong");
   bit_level_a: assert property (sfrReq.wr && sfrReq.bitOp && sfrReq.addr == 8'hB8 &&
      sfrReq.bitSel < 3'h6 |-> ##2 srcLevel[$past(sfrReq.bitSel, 2)] == $past(sfrReq.wdata[0], 2))
      else $error("bit write lost");
   grant_level_a: assert property (grant.valid && $stable(srcLevel)
      |-> grant.level == srcLevel[grant.source]) else $error("grant level wrong");
   high_hold_a: assert property ((irqAck && grant.valid && grant.level) ##1
      (!handlerReturn) [*2] |-> !grant.valid) else $error("high handler pre-empted");
   low_hold_a: assert property ((irqAck && grant.valid && !grant.level) ##1
      (!handlerReturn) [*2] |-> !grant.valid || grant.level) else $error("low pre-empts low");
   ack_clear_a: assert property (irqAck || handlerReturn |=> !grant.valid)
      else $error("grant not withdrawn");
endmodule
bind interrupt_priority_select interrupt_priority_select_properties #(.NUM_SRC(NUM_SRC)) props (
   .clock, .nrst, .sfrReq, .sfrRdata, .sfrRvalid, .irqPending, .irqAck, .handlerReturn,
   .grant, .srcLevel);
`default_nettype wire

// ===== verif/interrupt_priority_select_tb.sv
`default_nettype none
module interrupt_priority_select_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} row_t;
   logic clock = 0;
   logic nrst = 0;
   logic retReq = 0;
   irq_priority_pkg::sfr_req_t sfrReq = '0;
   logic [13:0] irqPending = '0;
   logic [13:0] srcLevel, expLvl;
   logic [7:0] sfrRdata;
   logic sfrRvalid, irqAck, handlerReturn;
   irq_priority_pkg::irq_grant_t grant, taken;
   int fails = 0;
   int num_checks = 0;
   row_t rows [8] = '{'{8'hB8, 8'hFF, 8'h3F}, '{8'hB8, 8'h00, 8'h00}, '{8'hF8, 8'hA5, 8'hA5},
      '{8'hF8, 8'h5A, 8'h5A}, '{8'hA8, 8'hFF, 8'hBF}, '{8'hE8, 8'h3C, 8'h3C},
      '{8'h77, 8'hFF, 8'h00}, '{8'hB8, 8'h2A, 8'h2A}};
   always #20 clock = ~clock;
   interrupt_priority_select uut (.clock, .nrst, .sfrReq, .sfrRdata, .sfrRvalid, .irqPending,
      .irqAck, .handlerReturn, .grant, .srcLevel);
   irq_core_model #(.ACK_DELAY(3)) core (.clock, .nrst, .grant, .irqAck, .handlerReturn,
      .retReq, .taken);
   task automatic chk(input logic [15:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, r, input logic [7:0] a, d, input logic b,
      input logic [2:0] s);
      @(posedge clock);
      sfrReq <= '{a, d, w, r, b, s};
      @(posedge clock);
      sfrReq <= '0;
   endtask
   task automatic rd(input logic [7:0] a, e);
      acc(0, 1, a, 8'h00, 0, 3'h0);
      #1 chk({7'h00, sfrRvalid, sfrRdata}, {8'h01, e});
   endtask
   task automatic pend(input logic [13:0] v);
      @(posedge clock);
      irqPending <= v;
   endtask
   task automatic ret();
      @(posedge clock);
      retReq <= 1'b1;
      @(posedge clock);
      retReq <= 1'b0;
   endtask
   // each scenario ends with a compare, so callers pass the expected source and level
   task automatic expAck(input logic [3:0] src, input logic lvl);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 30 && !seen; i++) begin
         @(posedge clock) #1;
         seen = (irqAck === 1'b1);
      end
      // the core records the offer at the edge where the ack is sampled
      @(posedge clock) #1;
      chk({10'h000, seen, taken.level, taken.source}, {10'h001, lvl, src});
   endtask
   task automatic noAck();
      logic seen;
      seen = 1'b0;
      repeat (10) begin
         @(posedge clock) #1;
         seen = seen | irqAck;
      end
      chk({15'h0000, seen}, 16'h0000);
   endtask
   task automatic results();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #(40 * 3000);
      fails++;
      results();
   end
   initial begin
      expLvl = '0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      rd(8'hB8, 8'h00);
      rd(8'hF8, 8'h00);
      foreach (rows[i]) begin
         acc(1, 0, rows[i].addr, rows[i].wdata, 0, 3'h0);
         rd(rows[i].addr, rows[i].rexp);
         if (rows[i].addr == 8'hB8) expLvl[5:0] = rows[i].rexp[5:0];
         if (rows[i].addr == 8'hF8) expLvl[13:6] = rows[i].rexp;
         chk({2'h0, srcLevel}, {2'h0, expLvl});
      end
      acc(1, 0, 8'hB8, 8'h01, 1, 3'h6);
      acc(1, 0, 8'hB8, 8'h01, 1, 3'h0);
      acc(1, 0, 8'hB8, 8'h00, 1, 3'h5);
      rd(8'hB8, 8'h0B);
      acc(1, 0, 8'hA8, 8'hFF, 0, 3'h0);
      acc(1, 0, 8'hE8, 8'hFF, 0, 3'h0);
      acc(1, 0, 8'hB8, 8'h10, 0, 3'h0);
      acc(1, 0, 8'hF8, 8'h01, 0, 3'h0);
      pend(14'h0005);
      expAck(4'h0, 1'b0);
      pend(14'h0004);
      noAck();
      pend(14'h0014);
      expAck(4'h4, 1'b1);
      pend(14'h0044);
      noAck();
      ret();
      expAck(4'h6, 1'b1);
      pend(14'h0004);
      ret();
      noAck();
      ret();
      expAck(4'h2, 1'b0);
      ret();
      acc(1, 0, 8'hA8, 8'h3F, 0, 3'h0);
      pend(14'h0001);
      noAck();
      acc(1, 0, 8'hA8, 8'hFF, 0, 3'h0);
      expAck(4'h0, 1'b0);
      pend(14'h0000);
      ret();
      acc(1, 0, 8'hE8, 8'hFD, 0, 3'h0);
      pend(14'h0080);
      noAck();
      acc(1, 0, 8'hE8, 8'hFF, 0, 3'h0);
      expAck(4'h7, 1'b0);
      pend(14'h0000);
      ret();
      pend(14'h0050);
      expAck(4'h4, 1'b1);
      pend(14'h0040);
      noAck();
      ret();
      expAck(4'h6, 1'b1);
      results();
   end
endmodule
`default_nettype wire

// ===== verif/irq_core_model.sv
`default_nettype none
module irq_core_model #(parameter int ACK_DELAY = 2) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // controller side
   input wire irq_priority_pkg::irq_grant_t grant,
   output logic irqAck,
   output logic handlerReturn,
   // bench side
   input wire logic retReq,
   output irq_priority_pkg::irq_grant_t taken
);
   int waitCnt;
   // slow core: an offer must stand ACK_DELAY+1 cycles before it is acked
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         waitCnt <= 0;
         irqAck <= 1'b0;
         handlerReturn <= 1'b0;
         taken <= '0;
      end else begin
         irqAck <= 1'b0;
         handlerReturn <= retReq;
         waitCnt <= (grant.valid && !irqAck) ? waitCnt + 1 : 0;
         if (grant.valid && !irqAck && waitCnt == ACK_DELAY) begin
            irqAck <= 1'b1;
            waitCnt <= 0;
         end
         // keep the offer that stands when the controller samples the ack
         if (irqAck && grant.valid) taken <= grant;
      end
   end
endmodule
`default_nettype wire
